// ---- hdl/ubl_map.vh ----
`ifndef UBL_MAP_VH
`define UBL_MAP_VH
`define UBL_SYSCFG_BOOT 16'h0400
`define UBL_SYSCFG_MEM_EN_BIT 10
`define UBL_SYSCFG_HI_DIS_BIT 9
`define UBL_CTX_BASE 16'hFA00
`define UBL_STK_UNDER 16'hFA00
`define UBL_STK_TOP 16'hFA40
`define UBL_STK_OVER 16'hFC00
`define UBL_SERCTL_BOOT 16'h8011
`define UBL_BUSCFG_OFF 16'h0000
`define UBL_BUSCFG_ACT_BIT 10
`define UBL_BUSCFG_ALE_BIT 9
`define UBL_BUSCFG_TYP_LO 6
`define UBL_LOAD_BASE 16'hFA40
`define UBL_LOAD_LAST 16'hFA5F
`define UBL_LOAD_COUNT 6'd32
`define UBL_MEAS_OFFSET 16'd36
`define UBL_MEAS_DIVISOR 16'd72
`define UBL_FLASH_LO 24'h01_0000
`define UBL_FLASH_HI 24'h08_FFFF
`define UBL_CLK_MHZ 100
`define UBL_INIT_US 1000
`define UBL_INIT_CYC (`UBL_INIT_US * `UBL_CLK_MHZ)
`define UBL_TXEN_US 1300
`define UBL_TXEN_CYC (`UBL_TXEN_US * `UBL_CLK_MHZ)
`define UBL_SYNC_W 16
`define UBL_PARTICLE 1
`define UBL_OFF_STATUS 8'h00
`define UBL_OFF_BAUD 8'h04
`define UBL_OFF_SYSCFG 8'h08
`define UBL_OFF_BUSCFG 8'h0C
`define UBL_OFF_SERCTL 8'h10
`define UBL_OFF_PTRS 8'h14
`define UBL_OFF_STACK 8'h18
`define UBL_OFF_RAM 8'h80
`endif

// ---- hdl/ubl_uart.v ----
`timescale 1ns/1ns
// 8n1 byte engine; one bit lasts 32*(reload+1) cycles of pclk
module ubl_uart (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire [12:0] reload,
    input wire rx,
    output reg rx_valid,
    output reg [7:0] rx_data,
    input wire tx_start,
    input wire [7:0] tx_data,
    output wire tx_busy,
    output reg tx
);
    wire [17:0] bit_len;
    reg [17:0] rx_cnt_reg;
    reg [3:0] rx_bit_reg;
    reg [7:0] rx_sh_reg;
    reg rx_act_reg;
    reg [17:0] tx_cnt_reg;
    reg [3:0] tx_bit_reg;
    reg [9:0] tx_sh_reg;
    reg tx_act_reg;
    assign bit_len = {reload, 5'h00} + 18'h0_0020;
    assign tx_busy = tx_act_reg | tx_start;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= 18'h0_0000;
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!enable) begin
                rx_act_reg <= 1'b0;
            end else if (!rx_act_reg) begin
                if (!rx) begin
                    rx_act_reg <= 1'b1;
                    rx_cnt_reg <= {1'b0, bit_len[17:1]};
                    rx_bit_reg <= 4'h0;
                end
            end else if (rx_cnt_reg == 18'h0_0000) begin
                rx_cnt_reg <= bit_len - 18'h0_0001;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h0 && rx) begin
                    rx_act_reg <= 1'b0;
                end else if (rx_bit_reg == 4'h9) begin
                    rx_act_reg <= 1'b0;
                    if (rx) begin
                        rx_valid <= 1'b1;
                        rx_data <= rx_sh_reg;
                    end
                end else if (rx_bit_reg != 4'h0) begin
                    rx_sh_reg <= {rx, rx_sh_reg[7:1]};
                end
            end else begin
                rx_cnt_reg <= rx_cnt_reg - 18'h0_0001;
            end
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_act_reg <= 1'b0;
            tx_cnt_reg <= 18'h0_0000;
            tx_bit_reg <= 4'h0;
            tx_sh_reg <= 10'h3FF;
            tx <= 1'b1;
        end else if (!tx_act_reg) begin
            tx <= 1'b1;
            if (tx_start) begin
                tx_act_reg <= 1'b1;
                tx_sh_reg <= {1'b1, tx_data, 1'b0};
                tx_cnt_reg <= 18'h0_0000;
                tx_bit_reg <= 4'h0;
            end
        end else if (tx_cnt_reg == 18'h0_0000) begin
            if (tx_bit_reg == 4'hA) begin
                tx_act_reg <= 1'b0;
                tx <= 1'b1;
            end else begin
                tx <= tx_sh_reg[0];
                tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                tx_bit_reg <= tx_bit_reg + 4'h1;
                tx_cnt_reg <= bit_len - 18'h0_0001;
            end
        end else begin
            tx_cnt_reg <= tx_cnt_reg - 18'h0_0001;
        end
    end
endmodule // ubl_uart

// ---- hdl/ubl_boot_loader.v ----
`timescale 1ns/1ns
`include "ubl_map.vh"
module ubl_boot_loader #(
    parameter INIT_CYC = `UBL_INIT_CYC,
    parameter TXEN_CYC = `UBL_TXEN_CYC,
    parameter ACK_BYTE = 8'h5A
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire boot_select_pin,
    input wire external_access_select,
    input wire [1:0] port0_bus_type,
    input wire port0_byte_bus,
    input wire sw_reset,
    input wire boot_serial_rx,
    output wire boot_serial_tx,
    output wire boot_serial_tx_oe,
    input wire fetch_req,
    input wire [23:0] fetch_addr,
    output wire fetch_to_boot_flash,
    input wire data_read,
    input wire flash_present,
    output wire data_read_valid,
    output wire watchdog_disable,
    output wire boot_loader_mode,
    output reg branch_pulse,
    output wire [15:0] branch_addr
);
    localparam ST_CAPTURE = 3'd0;
    localparam ST_INIT = 3'd1;
    localparam ST_MEASURE = 3'd2;
    localparam ST_TXWAIT = 3'd3;
    localparam ST_ACK = 3'd4;
    localparam ST_LOAD = 3'd5;
    localparam ST_RUN = 3'd6;
    localparam ST_NORMAL = 3'd7;

    function in_flash;
        input [23:0] a;
        begin
            in_flash = (a >= `UBL_FLASH_LO) && (a <= `UBL_FLASH_HI);
        end
    endfunction

    reg [2:0] rx_sync_reg;
    reg rx_level_reg;
    reg [2:0] state_reg;
    reg mode_reg;
    reg [23:0] wait_reg;
    reg [`UBL_SYNC_W-1:0] meas_reg;
    reg meas_ovf_reg;
    reg meas_run_reg;
    reg [15:0] baud_generator_reg;
    reg [15:0] serial_control_reg;
    reg [15:0] system_config_reg;
    reg [15:0] bus_config_reg;
    reg [15:0] context_base_pointer;
    reg [15:0] stack_top_pointer;
    reg [15:0] stack_underflow_limit;
    reg [15:0] stack_overflow_limit;
    reg tx_port_bit;
    reg tx_direction_bit;
    reg [5:0] load_cnt_reg;
    reg [7:0] ram [0:31];
    reg ack_start_reg;
    wire rx_valid;
    wire [7:0] rx_data;
    wire tx_busy;
    wire uart_tx;
    wire uart_en;
    wire [15:0] reload_calc;
    wire [4:0] ram_idx;
    reg [1:0] div_reg;
    wire meas_tick;

    assign uart_en = (state_reg == ST_LOAD) || (state_reg == ST_RUN);
    assign meas_tick = (div_reg == 2'b11);
    // meas_reg < 36 would wrap; clamp to zero instead
    assign reload_calc = (meas_reg > `UBL_MEAS_OFFSET) ?
        ((meas_reg - `UBL_MEAS_OFFSET) / `UBL_MEAS_DIVISOR) : 16'h0000;

    ubl_uart u_uart (
        .pclk(pclk),
        .presetn(presetn),
        .enable(uart_en),
        .reload(baud_generator_reg[12:0]),
        .rx(rx_level_reg),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .tx_start(ack_start_reg),
        .tx_data(ACK_BYTE),
        .tx_busy(tx_busy),
        .tx(uart_tx)
    );

    // divide-by-four enable: nine low bits then give 9/4 of the host's bit in ticks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'b00;
        end else if (meas_run_reg) begin
            div_reg <= div_reg + 2'b01;
        end else begin
            div_reg <= 2'b00;
        end
    end

    // pin sampled through three stages; level updates once the last two agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync_reg <= 3'b111;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], boot_serial_rx};
            if (rx_sync_reg[2] == rx_sync_reg[1]) begin
                rx_level_reg <= rx_sync_reg[2];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_CAPTURE;
            mode_reg <= 1'b0;
            wait_reg <= 24'h00_0000;
            meas_reg <= 16'h0000;
            meas_ovf_reg <= 1'b0;
            meas_run_reg <= 1'b0;
            baud_generator_reg <= 16'h0000;
            serial_control_reg <= 16'h0000;
            system_config_reg <= 16'h0000;
            bus_config_reg <= 16'h0000;
            context_base_pointer <= 16'h0000;
            stack_top_pointer <= 16'h0000;
            stack_underflow_limit <= 16'h0000;
            stack_overflow_limit <= 16'h0000;
            tx_port_bit <= 1'b0;
            tx_direction_bit <= 1'b0;
            load_cnt_reg <= 6'd0;
            ack_start_reg <= 1'b0;
            branch_pulse <= 1'b0;
        end else begin
            ack_start_reg <= 1'b0;
            branch_pulse <= 1'b0;
            if (sw_reset) begin
                mode_reg <= 1'b0;
                state_reg <= ST_NORMAL;
            end else begin
                case (state_reg)
                ST_CAPTURE: begin
                    // straps caught at first edge after release
                    if (!boot_select_pin) begin
                        mode_reg <= 1'b1;
                        state_reg <= ST_INIT;
                        system_config_reg <= `UBL_SYSCFG_BOOT;
                        system_config_reg[`UBL_SYSCFG_MEM_EN_BIT] <= 1'b1;
                        system_config_reg[`UBL_SYSCFG_HI_DIS_BIT] <= port0_byte_bus;
                        context_base_pointer <= `UBL_CTX_BASE;
                        stack_underflow_limit <= `UBL_STK_UNDER;
                        stack_top_pointer <= `UBL_STK_TOP;
                        stack_overflow_limit <= `UBL_STK_OVER;
                        if (external_access_select) begin
                            bus_config_reg <= `UBL_BUSCFG_OFF;
                        end else begin
                            bus_config_reg <= `UBL_BUSCFG_OFF;
                            bus_config_reg[`UBL_BUSCFG_ACT_BIT] <= 1'b1;
                            bus_config_reg[`UBL_BUSCFG_ALE_BIT] <= 1'b1;
                            bus_config_reg[`UBL_BUSCFG_TYP_LO+1 -: 2] <= port0_bus_type;
                        end
                        wait_reg <= 24'h00_0000;
                    end else begin
                        state_reg <= ST_NORMAL;
                    end
                end
                ST_INIT: begin
                    // line must sit idle high through init
                    if (wait_reg >= INIT_CYC - 1) begin
                        state_reg <= ST_MEASURE;
                        meas_run_reg <= 1'b0;
                        meas_reg <= 16'h0000;
                        meas_ovf_reg <= 1'b0;
                    end else begin
                        wait_reg <= wait_reg + 24'h00_0001;
                    end
                end
                ST_MEASURE: begin
                    // timer spans start bit plus eight zero bits at pclk/4
                    if (!meas_run_reg) begin
                        if (!rx_level_reg) begin
                            meas_run_reg <= 1'b1;
                            meas_reg <= 16'h0000;
                        end
                    end else if (!rx_level_reg) begin
                        if (meas_tick) begin
                            if (meas_reg == 16'hFFFF) begin
                                meas_ovf_reg <= 1'b1;
                            end
                            meas_reg <= meas_reg + 16'h0001;
                        end
                    end else begin
                        meas_run_reg <= 1'b0;
                        // overflowed count still programs; channel then misfires
                        baud_generator_reg <= reload_calc;
                        serial_control_reg <= `UBL_SERCTL_BOOT;
                        tx_port_bit <= 1'b1;
                        wait_reg <= 24'h00_0000;
                        state_reg <= ST_TXWAIT;
                    end
                end
                ST_TXWAIT: begin
                    if (wait_reg >= TXEN_CYC - 1) begin
                        tx_direction_bit <= 1'b1;
                        ack_start_reg <= 1'b1;
                        state_reg <= ST_ACK;
                    end else begin
                        wait_reg <= wait_reg + 24'h00_0001;
                    end
                end
                ST_ACK: begin
                    if (!tx_busy) begin
                        load_cnt_reg <= 6'd0;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (rx_valid) begin
                        load_cnt_reg <= load_cnt_reg + 6'd1;
                        if (load_cnt_reg == `UBL_LOAD_COUNT - 6'd1) begin
                            branch_pulse <= 1'b1;
                            state_reg <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
                ST_NORMAL: begin
                    state_reg <= ST_NORMAL;
                end
                default: begin
                    state_reg <= ST_NORMAL;
                end
                endcase
            end
        end
    end

    assign ram_idx = load_cnt_reg[4:0];
    always @(posedge pclk) begin
        if (state_reg == ST_LOAD && rx_valid) begin
            ram[ram_idx] <= rx_data;
        end
    end

    assign boot_loader_mode = mode_reg;
    assign watchdog_disable = mode_reg;
    assign boot_serial_tx = tx_port_bit & uart_tx;
    assign boot_serial_tx_oe = tx_direction_bit;
    assign fetch_to_boot_flash = mode_reg & fetch_req & in_flash(fetch_addr);
    assign data_read_valid = data_read & flash_present;
    assign branch_addr = `UBL_LOAD_BASE;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // registers read-only here; loader owns them
    always @* begin
        prdata = 32'h0000_0000;
        // ram window runs to the top of the 8-bit address space
        if (paddr >= `UBL_OFF_RAM && paddr[1:0] == 2'b00) begin
            prdata = {24'h00_0000, ram[paddr[6:2]]};
        end else begin
            case (paddr)
            `UBL_OFF_STATUS: prdata = {16'h0000, meas_ovf_reg, 7'h00, tx_direction_bit,
                tx_port_bit, load_cnt_reg[5:0] == `UBL_LOAD_COUNT ? 1'b1 : 1'b0,
                mode_reg, 1'b0, state_reg};
            `UBL_OFF_BAUD: prdata = {meas_reg, baud_generator_reg};
            `UBL_OFF_SYSCFG: prdata = {16'h0000, system_config_reg};
            `UBL_OFF_BUSCFG: prdata = {16'h0000, bus_config_reg};
            `UBL_OFF_SERCTL: prdata = {16'h0000, serial_control_reg};
            `UBL_OFF_PTRS: prdata = {context_base_pointer, stack_top_pointer};
            `UBL_OFF_STACK: prdata = {stack_underflow_limit, stack_overflow_limit};
            default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // ubl_boot_loader

// ---- tb/ubl_boot_loader_props.sv ----
`timescale 1ns/1ns
module ubl_boot_loader_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic boot_select_pin,
    input wire logic sw_reset,
    input wire logic boot_serial_tx,
    input wire logic boot_serial_tx_oe,
    input wire logic fetch_req,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_to_boot_flash,
    input wire logic data_read,
    input wire logic flash_present,
    input wire logic data_read_valid,
    input wire logic watchdog_disable,
    input wire logic boot_loader_mode,
    input wire logic branch_pulse,
    input wire logic [15:0] branch_addr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_entry_select: assert property (
        $rose(boot_loader_mode) |-> !$past(boot_select_pin)) else $error("entry without select");
    a_sw_exit: assert property (
        sw_reset |=> !boot_loader_mode) else $error("mode kept after software reset");
    a_mode_stays: assert property (
        boot_loader_mode && !sw_reset |=> boot_loader_mode) else $error("boot mode dropped");
    a_watchdog_off: assert property (
        boot_loader_mode |-> watchdog_disable) else $error("watchdog on in boot mode");
    a_branch_target: assert property (
        branch_pulse |-> branch_addr == 16'hFA40 && boot_loader_mode) else $error("bad branch");
    a_branch_once: assert property (
        branch_pulse |=> !branch_pulse [*8]) else $error("branch repeated");
    a_tx_idle_high: assert property (
        $rose(boot_serial_tx_oe) |-> boot_serial_tx) else $error("tx low when first driven");
    a_oe_holds: assert property (
        boot_serial_tx_oe && boot_loader_mode && !sw_reset |=> boot_serial_tx_oe)
        else $error("tx enable dropped");
    a_oe_needs_mode: assert property (
        $rose(boot_serial_tx_oe) |-> boot_loader_mode) else $error("tx driven outside boot");
    a_fetch_redirect: assert property (
        fetch_to_boot_flash == (boot_loader_mode && fetch_req && fetch_addr >= 24'h01_0000
        && fetch_addr <= 24'h08_FFFF)) else $error("fetch redirect wrong");
    a_data_read: assert property (
        data_read_valid == (data_read && flash_present)) else $error("data read path wrong");

    c_branch: cover property (branch_pulse);
    c_tx_on: cover property ($rose(boot_serial_tx_oe));
    c_fetch: cover property (fetch_to_boot_flash);
    c_sw_exit: cover property (sw_reset && boot_loader_mode);
endmodule // ubl_boot_loader_props

bind ubl_boot_loader ubl_boot_loader_props u_props (.pclk(pclk), .presetn(presetn),
    .boot_select_pin(boot_select_pin), .sw_reset(sw_reset), .boot_serial_tx(boot_serial_tx),
    .boot_serial_tx_oe(boot_serial_tx_oe), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_to_boot_flash(fetch_to_boot_flash), .data_read(data_read),
    .flash_present(flash_present), .data_read_valid(data_read_valid),
    .watchdog_disable(watchdog_disable), .boot_loader_mode(boot_loader_mode),
    .branch_pulse(branch_pulse), .branch_addr(branch_addr));

// ---- tb/ubl_host_model.sv ----
`timescale 1ns/1ns
module ubl_host_model (
    input wire logic pclk,
    input wire logic line_in,
    output logic rx_out
);
    initial rx_out = 1'b1;
    // host drives no segment or CAN lines at all

    // start bit plus eight zero bits, then idle high again
    task automatic send_zero(input int bit_cyc);
        @(posedge pclk);
        rx_out <= 1'b0;
        repeat (9 * bit_cyc) @(posedge pclk);
        rx_out <= 1'b1;
    endtask

    task automatic send_byte(input logic [7:0] d, input int bit_cyc);
        logic [9:0] frame;
        frame = {1'b1, d, 1'b0};
        @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            rx_out <= frame[i];
            repeat (bit_cyc) @(posedge pclk);
        end
    endtask

    // the rate is learned from the start bit, so the reply needs bit 0 set
    task automatic recv_byte(output logic [7:0] d, output int bit_cyc);
        int n;
        n = 0;
        d = 8'h00;
        bit_cyc = 0;
        while (line_in && n < 50000) begin
            @(posedge pclk);
            n++;
        end
        while (!line_in && bit_cyc < 5000) begin
            @(posedge pclk);
            bit_cyc++;
        end
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            if (i > 0) repeat (bit_cyc) @(posedge pclk);
            d[i] = line_in;
        end
        // return only at the end of the stop bit, when the loader listens
        repeat (bit_cyc + bit_cyc / 2) @(posedge pclk);
    endtask
endmodule // ubl_host_model

// ---- tb/tb_ubl_boot_loader.sv ----
`timescale 1ns/1ns
module tb_ubl_boot_loader;
    localparam int INIT = 100;
    localparam int TXEN = 200;
    // above 19200 baud, allowed as the derived rate matches exactly
    localparam int HOST_BIT = 64;
    // arbitrary value; bit 0 set so the host can time the start bit
    localparam logic [7:0] ACK = 8'hC3;
    localparam logic [7:0] RA [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    localparam logic [31:0] RE [5] = '{32'h0000_0600, 32'h0000_0000, 32'h0000_8011,
        32'hFA00_FA40, 32'hFA00_FC00};
    localparam logic [23:0] FA [4] = '{24'h00_FFFF, 24'h01_0000, 24'h08_FFFF, 24'h09_0000};
    logic pclk, presetn, psel, penable, pwrite, sel, ea, byte_bus, swr, rx;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic [1:0] bus_type_field;
    logic freq, dread, fpres;
    logic [23:0] faddr;
    wire [31:0] prdata;
    wire [15:0] baddr;
    wire pready, pslverr, tx, oe, fboot, dvalid, wdog, mode, bpulse;
    wire tx_line = oe ? tx : 1'b1;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int branches = 0;
    int n, bit_cyc;
    logic [7:0] ack;

    ubl_boot_loader #(.INIT_CYC(INIT), .TXEN_CYC(TXEN), .ACK_BYTE(ACK)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_select_pin(sel), .external_access_select(ea), .port0_bus_type(bus_type_field),
        .port0_byte_bus(byte_bus), .sw_reset(swr), .boot_serial_rx(rx), .boot_serial_tx(tx),
        .boot_serial_tx_oe(oe), .fetch_req(freq), .fetch_addr(faddr),
        .fetch_to_boot_flash(fboot), .data_read(dread), .flash_present(fpres),
        .data_read_valid(dvalid), .watchdog_disable(wdog), .boot_loader_mode(mode),
        .branch_pulse(bpulse), .branch_addr(baddr));
    ubl_host_model u_host (.pclk(pclk), .line_in(tx_line), .rx_out(rx));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (bpulse) branches <= branches + 1;
        if (cyc == 60000) begin
            miscompares++;
            final_report;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic hw_reset(input logic s, input logic e, input logic [1:0] t, input logic b);
        @(posedge pclk);
        presetn <= 1'b0;
        sel <= s;
        ea <= e;
        bus_type_field <= t;
        byte_bus <= b;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'hA5 ^ 8'(i * 29);
    endfunction

    initial begin
        {presetn, psel, penable, pwrite, swr, freq, dread, fpres} = '0;
        {sel, ea, byte_bus, bus_type_field, paddr, pwdata, faddr} = '0;
        hw_reset(1'b0, 1'b1, 2'b01, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd & 32'h90, 32'h0000_0010);
        chk({31'b0, pslverr}, 32'h0);
        repeat (INIT + 50) @(posedge pclk);
        u_host.send_zero(HOST_BIT);
        for (n = 0; n < TXEN + 100 && !oe; n++) @(posedge pclk);
        chk({31'b0, n >= TXEN - 20 && oe}, 32'h1);
        u_host.recv_byte(ack, bit_cyc);
        chk({24'b0, ack}, {24'b0, ACK});
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'hFFFF, (9 * HOST_BIT / 4 - 36) / 72);
        chk({31'b0, bit_cyc * 40 > HOST_BIT * 39 && bit_cyc * 40 < HOST_BIT * 41}, 32'h1);
        $display("test zero byte and acknowledge done");
        for (int i = 0; i < 32; i++) u_host.send_byte(pat(i), HOST_BIT);
        repeat (4 * HOST_BIT) @(posedge pclk);
        chk(branches, 1);
        for (int i = 0; i < 32; i++) begin
            apb(1'b0, 8'h80 + 8'(4 * i), 32'h0);
            chk(rd & 32'hFF, {24'b0, pat(i)});
        end
        apb(1'b1, 8'h08, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, RA[i], 32'h0);
            chk(rd, RE[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd & 32'h8090, 32'h0000_0090);
        $display("test load and configuration done");
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            freq <= 1'b1;
            faddr <= FA[i];
            dread <= 1'b1;
            fpres <= i[0];
            @(negedge pclk);
            chk({31'b0, fboot}, {31'b0, i == 1 || i == 2});
            chk({30'b0, dvalid, wdog}, {30'b0, i[0], 1'b1});
        end
        @(posedge pclk);
        swr <= 1'b1;
        @(posedge pclk);
        swr <= 1'b0;
        @(negedge pclk);
        chk({31'b0, mode}, 32'h0);
        hw_reset(1'b1, 1'b0, 2'b10, 1'b0);
        chk({31'b0, mode}, 32'h0);
        hw_reset(1'b0, 1'b0, 2'b10, 1'b0);
        chk({31'b0, mode}, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_0400);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0000_0680);
        $display("test exit and strap variants done");
        final_report;
    end
endmodule // tb_ubl_boot_loader
